// ===== verification/core_model.sv
/*
 Model of the core's branch retirement side: plays queued branches,
 one per clock, back to back while the queue holds any.
 Assumes the bench pushes {kind, ring, flags, source, target} into q.
*/
`default_nettype none
module core_model (
   // Clock
   input wire logic ref_clk,
   // Retired branch
   output logic retire_valid,
   output logic [2:0] retire_kind,
   output logic [47:0] retire_src,
   output logic [47:0] retire_dst,
   output logic [1:0] retire_ring,
   output logic retire_mispredict,
   output logic retire_in_txn,
   output logic retire_txn_abort,
   output logic retire_zero_len_call
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [104:0] q[$];
   initial
   begin
      retire_valid = 1'b0;
      {retire_kind, retire_ring, retire_src, retire_dst} = '0;
      {retire_mispredict, retire_in_txn, retire_txn_abort, retire_zero_len_call} = 4'h0;
   end
   always @(posedge ref_clk)
   begin
      if (q.size() > 0)
      begin
         retire_valid <= 1'b1;
         {retire_kind, retire_ring, retire_mispredict, retire_in_txn, retire_txn_abort,
          retire_zero_len_call, retire_src, retire_dst} <= q.pop_front();
      end
      else
      begin
         // Idle address, kind and ring lines mean nothing: flip them so no one leans on stale values
         retire_valid <= 1'b0;
         retire_src <= ~retire_src;
         retire_dst <= ~retire_dst;
         retire_kind <= ~retire_kind;
         retire_ring <= ~retire_ring;
      end
   end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
/*
 Self-checking bench of the branch record block: Avalon-MM register
 traffic and retired branches from the core model.
 Assumes brec_params.svh, the package and the design are compiled first.
*/
`include "brec_params.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic retire_valid, retire_mispredict, retire_in_txn, retire_txn_abort;
   logic retire_zero_len_call;
   logic [2:0] retire_kind;
   logic [47:0] retire_src, retire_dst;
   logic [1:0] retire_ring, r;
   logic [3:0] p;
   int n_fail, comparisons, seq;

   branch_record_callstack_filter uut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .retire_valid(retire_valid),
      .retire_kind(retire_kind), .retire_src(retire_src), .retire_dst(retire_dst),
      .retire_ring(retire_ring), .retire_mispredict(retire_mispredict),
      .retire_in_txn(retire_in_txn), .retire_txn_abort(retire_txn_abort),
      .retire_zero_len_call(retire_zero_len_call));
   core_model core (
      .ref_clk(ref_clk), .retire_valid(retire_valid), .retire_kind(retire_kind),
      .retire_src(retire_src), .retire_dst(retire_dst), .retire_ring(retire_ring),
      .retire_mispredict(retire_mispredict), .retire_in_txn(retire_in_txn),
      .retire_txn_abort(retire_txn_abort), .retire_zero_len_call(retire_zero_len_call));

   always #50 ref_clk = ~ref_clk;

   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= 4'hF;
      avs_write <= w;
      avs_read <= !w;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && n < 100)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 100)
      begin
         n_fail++;
         $display("Error at %0t: no answer from register bus", $time);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic chk(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      comparisons++;
      if (q !== e)
      begin
         n_fail++;
         $display("Error at %0t: addr %h read %h expected %h", $time, a, q, e);
      end
   endtask

   // Waits for the queue to drain, then two edges for the capture itself
   task automatic put(input logic [2:0] k, input logic [1:0] g, input logic [3:0] f,
                      input logic [47:0] s, input logic [47:0] d);
      int n;
      n = 0;
      core.q.push_back({k, g, f, s, d});
      while (core.q.size() > 0 && n < 100)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 100)
      begin
         n_fail++;
         $display("Error at %0t: branch queue did not drain", $time);
      end
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic step(input logic [2:0] k, input logic [1:0] g, input logic z,
                       input logic [3:0] e);
      seq++;
      put(k, g, {3'b000, z}, {32'h0000_0000, seq[15:0]}, {32'h0000_0FFF, seq[15:0]});
      chk(`ADDR_TOP_POINTER, {28'h000_0000, e});
   endtask

   function automatic logic [9:0] ent(input logic [3:0] i, input logic [3:0] o);
      return {`RECORD_REGION, i, o};
   endfunction

   task automatic done(input string name);
      $display("Test %s finished", name);
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("Error at %0t: watchdog expired", $time);
      summarize();
   end

   initial
   begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
      n_fail = 0;
      comparisons = 0;
      seq = 0;
      p = 4'h0;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      chk(`ADDR_DEBUG_CONTROL, 32'h0000_0000);
      chk(`ADDR_TOP_POINTER, 32'h0000_0000);
      chk(`ADDR_FILTER_LO, 32'h0000_0000);
      wr(`ADDR_FILTER_LO, 32'hFFFF_FFFF);
      wr(`ADDR_FILTER_HI, 32'hFFFF_FFFF);
      wr(`ADDR_PERF_CAP_LO, 32'h0000_0000);
      chk(`ADDR_FILTER_LO, 32'h0000_03FF);
      chk(`ADDR_FILTER_HI, 32'h0000_0000);
      chk(`ADDR_PERF_CAP_LO, 32'h0000_0004);
      chk(`ADDR_PERF_CAP_HI, 32'h0000_0000);
      chk(10'h100, 32'h0000_0000);
      wr(`ADDR_FILTER_LO, 32'h0000_0000);
      done("registers");
      step(3'h0, 2'h0, 1'b0, p);
      wr(`ADDR_DEBUG_CONTROL, 32'h0000_0001);
      for (int b = 0; b < 9; b++)
      begin
         wr(`ADDR_FILTER_LO, 32'h0000_0001 << b);
         for (int k = 0; k < 7; k++)
         begin
            r = k[0] ? 2'h3 : 2'h0;
            if (!((b == 0 && r == 2'h0) || (b == 1 && r != 2'h0) || b == k + 2))
               p = p + 4'h1;
            step(k[2:0], r, 1'b0, p);
         end
      end
      done("filters");
      wr(`ADDR_FILTER_LO, 32'h0000_0000);
      wr(`ADDR_TOP_POINTER, 32'h0000_000F);
      put(3'h6, 2'h3, 4'b1010, 48'h8000_0000_1234, 48'h8000_0000_5678);
      put(3'h0, 2'h0, 4'b0100, 48'h7FFF_0000_0001, 48'h0000_0000_0002);
      chk(`ADDR_TOP_POINTER, 32'h0000_0001);
      chk(ent(4'h0, 4'h0), 32'h0000_1234);
      chk(ent(4'h0, 4'h4), 32'hBFFF_8000);
      chk(ent(4'h0, 4'h8), 32'h0000_5678);
      chk(ent(4'h0, 4'hC), 32'hFFFF_8000);
      chk(ent(4'h1, 4'h4), 32'h4000_7FFF);
      done("record format");
      wr(`ADDR_FILTER_LO, 32'h0000_03C5);
      wr(`ADDR_TOP_POINTER, 32'h0000_0005);
      step(3'h1, 2'h3, 1'b0, 4'h6);
      step(3'h2, 2'h3, 1'b0, 4'h7);
      step(3'h0, 2'h3, 1'b0, 4'h7);
      step(3'h3, 2'h3, 1'b0, 4'h6);
      step(3'h1, 2'h3, 1'b1, 4'h6);
      step(3'h1, 2'h3, 1'b0, 4'h7);
      chk(ent(4'h7, 4'h0), {16'h0000, seq[15:0]});
      chk(ent(4'h7, 4'h8), {16'h0FFF, seq[15:0]});
      step(3'h1, 2'h0, 1'b0, 4'h7);
      core.q.push_back({3'h2, 2'h3, 4'h0, 48'h0000_0000_0001, 48'h0000_0000_0002});
      core.q.push_back({3'h1, 2'h3, 4'h0, 48'h0000_0000_0003, 48'h0000_0000_0004});
      step(3'h3, 2'h3, 1'b0, 4'h8);
      wr(`ADDR_TOP_POINTER, 32'h0000_0000);
      step(3'h3, 2'h3, 1'b0, 4'hF);
      done("call chain");
      wr(`ADDR_FILTER_LO, 32'h0000_0000);
      step(3'h3, 2'h3, 1'b0, 4'h0);
      wr(`ADDR_DEBUG_CONTROL, 32'h0000_0000);
      step(3'h1, 2'h3, 1'b0, 4'h0);
      done("ordinary mode");
      summarize();
   end
endmodule
`default_nettype wire

// ===== verilog/branch_record_callstack_filter.sv
/*
 Branch record ring with privilege and branch-type filters and a
 call-chain mode, reached over a 32-bit Avalon-MM slave.
 Assumes one retired branch per cycle from the core, synchronous to
 ref_clk, and a master that holds its request until waitrequest is low.
*/
`include "brec_params.svh"
`default_nettype none
module branch_record_callstack_filter #(
   parameter int DEPTH = 16,
   parameter int IDX_W = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register bus
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Retired branch from the core
   input wire logic retire_valid,
   input wire logic [2:0] retire_kind,
   input wire logic [47:0] retire_src,
   input wire logic [47:0] retire_dst,
   input wire logic [1:0] retire_ring,
   input wire logic retire_mispredict,
   input wire logic retire_in_txn,
   input wire logic retire_txn_abort,
   input wire logic retire_zero_len_call
);
   logic wait_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic record_enable_r;
   logic [`FILTER_WIDTH-1:0] filter_sel_r;
   logic [IDX_W-1:0] top_entry_pointer_r;

   logic [9:0] addr_word;
   logic rec_hit;
   logic wr_commit;
   logic rd_take;
   logic call_chain_mode_enable;
   logic ring_skip;
   logic type_skip;
   logic is_call;
   logic is_ret;
   logic capture_live;
   logic rec_push;
   logic rec_pop;
   logic [IDX_W-1:0] push_idx;
   logic [63:0] hw_src;
   logic [63:0] hw_tgt;
   logic [31:0] ring_word;

   assign addr_word = {avs_address[9:2], 2'h0};
   assign rec_hit = avs_address[9:8] == `RECORD_REGION;
   // Write lands at the edge where waitrequest is seen low
   assign wr_commit = avs_write && !wait_r;
   assign rd_take = avs_read && wait_r;

   // Bus handshake: one wait cycle, then a one-cycle release
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         wait_r <= 1'h1;
      else
         wait_r <= !((avs_read || avs_write) && wait_r);
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         rdata_r <= 32'h0000_0000;
      else if (rd_take)
         rdata_r <= rdata_nxt;
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata = rdata_r;

   // Filter select register, reserved bits read as zero
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         filter_sel_r <= `RESET_FILTER;
      else if (wr_commit && addr_word == `ADDR_FILTER_LO)
      begin
         if (avs_byteenable[0])
            filter_sel_r[7:0] <= avs_writedata[7:0];
         if (avs_byteenable[1])
            filter_sel_r[9:8] <= avs_writedata[9:8];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         record_enable_r <= `RESET_RECORD_ENABLE;
      else if (wr_commit && addr_word == `ADDR_DEBUG_CONTROL && avs_byteenable[0])
         record_enable_r <= avs_writedata[`BIT_RECORD_ENABLE];
   end

   // Branch classification
   assign call_chain_mode_enable = filter_sel_r[`BIT_CALL_CHAIN];
   assign is_call = retire_kind == brec_pkg::KIND_REL_CALL ||
                    retire_kind == brec_pkg::KIND_IND_CALL;
   assign is_ret = retire_kind == brec_pkg::KIND_RET;

   // Ring of the branch target decides
   assign ring_skip = (retire_ring == 2'h0) ? filter_sel_r[`BIT_SKIP_RING_ZERO] :
                      filter_sel_r[`BIT_SKIP_OUTER_RING];

   // Jump bits see only true jumps; calls and returns have own kinds
   always_comb
   begin
      case (retire_kind)
         brec_pkg::KIND_COND: type_skip = filter_sel_r[`BIT_SKIP_COND];
         brec_pkg::KIND_REL_CALL: type_skip = filter_sel_r[`BIT_SKIP_REL_CALL];
         brec_pkg::KIND_IND_CALL: type_skip = filter_sel_r[`BIT_SKIP_IND_CALL];
         brec_pkg::KIND_RET: type_skip = filter_sel_r[`BIT_SKIP_RET];
         brec_pkg::KIND_IND_JMP: type_skip = filter_sel_r[`BIT_SKIP_IND_JMP];
         brec_pkg::KIND_REL_JMP: type_skip = filter_sel_r[`BIT_SKIP_REL_JMP];
         brec_pkg::KIND_FAR: type_skip = filter_sel_r[`BIT_SKIP_FAR];
         default: type_skip = 1'h0;
      endcase
   end

   assign capture_live = retire_valid && record_enable_r && !ring_skip;

   // Mode clear: ordinary ring. Mode set: calls bypass type bits,
   // zero-length calls dropped, returns pop. Bad bit mixes are
   // software's fault and give whatever this logic yields.
   always_comb
   begin
      rec_push = 1'h0;
      rec_pop = 1'h0;
      if (capture_live && !call_chain_mode_enable)
         rec_push = !type_skip;
      else if (capture_live && is_call)
         rec_push = !retire_zero_len_call;
      else if (capture_live && is_ret)
         rec_pop = 1'h1;
      else if (capture_live)
         rec_push = !type_skip;
   end

   // Capture always lands one past the newest entry
   assign push_idx = top_entry_pointer_r + IDX_W'(1);

   // Top pointer: hardware update beats a same-edge software write
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         top_entry_pointer_r <= `RESET_TOP_POINTER;
      else if (rec_push)
         top_entry_pointer_r <= push_idx;
      else if (rec_pop)
         top_entry_pointer_r <= top_entry_pointer_r - IDX_W'(1);
      else if (wr_commit && addr_word == `ADDR_TOP_POINTER && avs_byteenable[0])
         top_entry_pointer_r <= avs_writedata[IDX_W-1:0];
   end

   // Source word layout
   assign hw_src = {retire_mispredict,
                    retire_in_txn,
                    retire_txn_abort,
                    {`SRC_EXT_WIDTH{retire_src[`SRC_ADDR_MSB]}},
                    retire_src};
   assign hw_tgt = {{`TGT_EXT_WIDTH{retire_dst[`SRC_ADDR_MSB]}}, retire_dst};

   record_ring_store #(
      .DEPTH(DEPTH),
      .IDX_W(IDX_W)
   ) u_store (
      .ref_clk(ref_clk),
      .hw_we(rec_push),
      .hw_idx(push_idx),
      .hw_src(hw_src),
      .hw_tgt(hw_tgt),
      .sw_we(wr_commit && rec_hit),
      .sw_idx(avs_address[IDX_W+3:4]),
      .sw_tgt(avs_address[3]),
      .sw_hi(avs_address[2]),
      .sw_data(avs_writedata),
      .sw_be(avs_byteenable),
      .rd_idx(avs_address[IDX_W+3:4]),
      .rd_tgt(avs_address[3]),
      .rd_hi(avs_address[2]),
      .rd_word(ring_word)
   );

   // Read mux; unmapped words read zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (rec_hit)
         rdata_nxt = ring_word;
      else
      begin
         case (addr_word)
            `ADDR_DEBUG_CONTROL: rdata_nxt[`BIT_RECORD_ENABLE] = record_enable_r;
            `ADDR_TOP_POINTER: rdata_nxt[IDX_W-1:0] = top_entry_pointer_r;
            `ADDR_FILTER_LO: rdata_nxt[`FILTER_WIDTH-1:0] = filter_sel_r;
            `ADDR_PERF_CAP_LO: rdata_nxt[5:0] = `PERF_RECORD_FORMAT;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   AST_RESET_STATE: assert property (@(posedge ref_clk)
      sys_rst |=> filter_sel_r == `RESET_FILTER && !record_enable_r && wait_r)
      else $error("Filter select not cleared by reset");

   AST_PUSH_ADVANCE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rec_push |=> top_entry_pointer_r == $past(top_entry_pointer_r) + IDX_W'(1))
      else $error("Pointer did not advance by one on capture");

   AST_POP_RETREAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rec_pop |=> top_entry_pointer_r == $past(top_entry_pointer_r) - IDX_W'(1))
      else $error("Pointer did not step back on return");

   AST_DISABLED_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !record_enable_r && !wr_commit |=> $stable(top_entry_pointer_r))
      else $error("Ring moved while recording disabled");

   AST_RING_ZERO_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && retire_ring == 2'h0 && filter_sel_r[`BIT_SKIP_RING_ZERO]
      |-> !rec_push && !rec_pop)
      else $error("Ring zero branch recorded while skipped");

   AST_IND_CALL_KEPT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && record_enable_r && !ring_skip && !call_chain_mode_enable &&
      retire_kind == brec_pkg::KIND_IND_CALL && !filter_sel_r[`BIT_SKIP_IND_CALL]
      |=> top_entry_pointer_r == $past(push_idx))
      else $error("Indirect call lost to jump filter");

   AST_REL_CALL_KEPT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && record_enable_r && !ring_skip && !call_chain_mode_enable &&
      retire_kind == brec_pkg::KIND_REL_CALL && !filter_sel_r[`BIT_SKIP_REL_CALL]
      |-> rec_push)
      else $error("Relative call lost to jump filter");

   AST_CHAIN_CALL: assert property (@(posedge ref_clk) disable iff (sys_rst)
      capture_live && call_chain_mode_enable && is_call && !retire_zero_len_call
      |-> rec_push ##1 top_entry_pointer_r == $past(push_idx))
      else $error("Call not recorded in call-chain mode");

   AST_ZERO_LEN_DROP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      call_chain_mode_enable && retire_zero_len_call && is_call |=> $stable(top_entry_pointer_r))
      else $error("Zero-length call was recorded");

   AST_CAP_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rd_take && !rec_hit && addr_word == `ADDR_PERF_CAP_LO
      |=> !avs_waitrequest && avs_readdata[5:0] == `PERF_RECORD_FORMAT)
      else $error("Capability format not reported");

   AST_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (avs_read || avs_write) && wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("Bus answer not one cycle after request");

   // Idle bus keeps the slave waiting, so a stray edge cannot commit
   AST_WAIT_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !avs_read && !avs_write |=> avs_waitrequest)
      else $error("Waitrequest low with no request");

   AST_OUTER_RING_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && retire_ring != 2'h0 && filter_sel_r[`BIT_SKIP_OUTER_RING]
      |-> !rec_push && !rec_pop)
      else $error("Outer ring branch recorded while skipped");

   AST_COND_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && retire_kind == brec_pkg::KIND_COND && filter_sel_r[`BIT_SKIP_COND]
      |-> !rec_push && !rec_pop)
      else $error("Conditional branch recorded while skipped");

   AST_REL_CALL_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && !call_chain_mode_enable && retire_kind == brec_pkg::KIND_REL_CALL &&
      filter_sel_r[`BIT_SKIP_REL_CALL] |-> !rec_push)
      else $error("Relative call recorded while skipped");

   AST_IND_CALL_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && !call_chain_mode_enable && retire_kind == brec_pkg::KIND_IND_CALL &&
      filter_sel_r[`BIT_SKIP_IND_CALL] |-> !rec_push)
      else $error("Indirect call recorded while skipped");

   AST_RET_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && !call_chain_mode_enable && retire_kind == brec_pkg::KIND_RET &&
      filter_sel_r[`BIT_SKIP_RET] |-> !rec_push && !rec_pop)
      else $error("Return recorded while skipped");

   AST_FAR_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && retire_kind == brec_pkg::KIND_FAR && filter_sel_r[`BIT_SKIP_FAR]
      |-> !rec_push && !rec_pop)
      else $error("Far branch recorded while skipped");

   AST_IND_JMP_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && retire_kind == brec_pkg::KIND_IND_JMP && filter_sel_r[`BIT_SKIP_IND_JMP]
      |-> !rec_push && !rec_pop)
      else $error("Indirect jump recorded while skipped");

   AST_REL_JMP_SKIP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      retire_valid && retire_kind == brec_pkg::KIND_REL_JMP && filter_sel_r[`BIT_SKIP_REL_JMP]
      |-> !rec_push && !rec_pop)
      else $error("Relative jump recorded while skipped");

   AST_MODE_CLEAR_PUSH: assert property (@(posedge ref_clk) disable iff (sys_rst)
      capture_live && !call_chain_mode_enable && !type_skip |-> rec_push && !rec_pop)
      else $error("Unfiltered branch not recorded in ring mode");

   AST_CHAIN_RET_POP: assert property (@(posedge ref_clk) disable iff (sys_rst)
      capture_live && call_chain_mode_enable && is_ret |-> rec_pop && !rec_push)
      else $error("Return did not drop newest record");

   AST_IDLE_NO_CAPTURE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !record_enable_r |-> !rec_push && !rec_pop)
      else $error("Capture while recording disabled");

   // Only checked when no capture competes, since hardware wins that edge
   AST_SW_POINTER: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wr_commit && addr_word == `ADDR_TOP_POINTER && avs_byteenable[0] && !rec_push && !rec_pop
      |=> top_entry_pointer_r == IDX_W'($past(avs_writedata)))
      else $error("Software pointer write lost");

   AST_FILTER_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wr_commit && addr_word == `ADDR_FILTER_LO && avs_byteenable[1:0] == 2'h3
      |=> {22'h00_0000, filter_sel_r} == ($past(avs_writedata) & 32'h0000_03FF))
      else $error("Filter select write did not land");

   AST_SRC_LAYOUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rec_push |-> hw_src[`SRC_ADDR_MSB:0] == retire_src &&
      hw_src[`SRC_ABORT_BIT-1:`SRC_ADDR_MSB+1] == {`SRC_EXT_WIDTH{retire_src[`SRC_ADDR_MSB]}})
      else $error("Source address or extension wrong");

   AST_SRC_ABORT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rec_push |-> hw_src[`SRC_ABORT_BIT] == retire_txn_abort)
      else $error("Abort flag not stored");

   AST_SRC_IN_TXN: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rec_push |-> hw_src[`SRC_IN_TXN_BIT] == retire_in_txn)
      else $error("Inside-transaction flag not stored");

   AST_SRC_MISPREDICTION_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rec_push |-> hw_src[`SRC_MISPREDICTION_FLAG_BIT] == retire_mispredict)
      else $error("Misprediction flag not stored");

   AST_TGT_LAYOUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      rec_push |-> hw_tgt[`SRC_ADDR_MSB:0] == retire_dst)
      else $error("Target address not stored with source");
endmodule
`default_nettype wire

// ===== verilog/brec_params.svh
/*
 Offsets, field positions, reset values and encodings of the branch
 record block. Assumes a 32-bit Avalon-MM slave with byte addresses.

 //Function
 //- filter bit 9 selects call-stack LIFO mode
 //- mode clear: ordinary ring, filter bits only
 //- bit 0 skips ring 0, bit 1 outer rings
 //- bits 2,3,4,5,8 each skip one branch class
 //- bit 6 skips indirect jumps, not calls/returns
 //- bit 7 skips relative jumps, not relative calls
 //- call-stack mode: calls recorded, returns drop newest
 //- calls stored as plain source/target pairs
 //- record only while debug control bit 0 set
 //- ring of 16 source/target pairs
 //- pointer advances modulo 16 before each write
 //- pointer is software writable, indexes newest
 //- call-stack mode ignores zero-length calls
 //- source bits 47:0 address, 60:48 sign extension
 //- source bit 61 marks transactional abort
 //- source bit 62 marks inside transaction
 //- source bit 63 marks misprediction
 //- capability bits 5:0 read 04h
 //- filter select clears to zero at reset
*/
`ifndef BREC_PARAMS_SVH
`define BREC_PARAMS_SVH

`define ADDR_DEBUG_CONTROL 10'h000
`define ADDR_TOP_POINTER 10'h008
`define ADDR_FILTER_LO 10'h010
`define ADDR_FILTER_HI 10'h014
`define ADDR_PERF_CAP_LO 10'h018
`define ADDR_PERF_CAP_HI 10'h01C
`define RECORD_REGION 2'h2

`define BIT_RECORD_ENABLE 0
`define BIT_SKIP_RING_ZERO 0
`define BIT_SKIP_OUTER_RING 1
`define BIT_SKIP_COND 2
`define BIT_SKIP_REL_CALL 3
`define BIT_SKIP_IND_CALL 4
`define BIT_SKIP_RET 5
`define BIT_SKIP_IND_JMP 6
`define BIT_SKIP_REL_JMP 7
`define BIT_SKIP_FAR 8
`define BIT_CALL_CHAIN 9
`define FILTER_WIDTH 10

`define RESET_FILTER 10'h000
`define RESET_RECORD_ENABLE 1'h0
`define RESET_TOP_POINTER 4'h0
`define PERF_RECORD_FORMAT 6'h04

`define SRC_ADDR_MSB 47
`define SRC_EXT_WIDTH 13
`define TGT_EXT_WIDTH 16
`define SRC_ABORT_BIT 61
`define SRC_IN_TXN_BIT 62
`define SRC_MISPREDICTION_FLAG_BIT 63

`endif

// ===== verilog/brec_pkg.sv
/*
 Types shared by the branch record block and its bench.
 Assumes the core encodes each retired branch with branch_kind_type.
*/
`default_nettype none
package brec_pkg;
   typedef enum logic [2:0] {
      KIND_COND = 3'h0,
      KIND_REL_CALL = 3'h1,
      KIND_IND_CALL = 3'h2,
      KIND_RET = 3'h3,
      KIND_IND_JMP = 3'h4,
      KIND_REL_JMP = 3'h5,
      KIND_FAR = 3'h6
   } branch_kind_type;
endpackage
`default_nettype wire

// ===== verilog/record_ring_store.sv
/*
 Storage for the source/target record pairs, with a hardware capture
 port, a software word port with byte enables, and a word read port.
 Assumes the caller never needs both write ports on one entry at once;
 if it happens, the hardware capture wins.
*/
`default_nettype none
module record_ring_store #(
   parameter int DEPTH = 16,
   parameter int IDX_W = 4
) (
   // Clock
   input wire logic ref_clk,
   // Hardware capture
   input wire logic hw_we,
   input wire logic [IDX_W-1:0] hw_idx,
   input wire logic [63:0] hw_src,
   input wire logic [63:0] hw_tgt,
   // Software word write
   input wire logic sw_we,
   input wire logic [IDX_W-1:0] sw_idx,
   input wire logic sw_tgt,
   input wire logic sw_hi,
   input wire logic [31:0] sw_data,
   input wire logic [3:0] sw_be,
   // Word read
   input wire logic [IDX_W-1:0] rd_idx,
   input wire logic rd_tgt,
   input wire logic rd_hi,
   output logic [31:0] rd_word
);
   logic [63:0] src_mem [DEPTH];
   logic [63:0] tgt_mem [DEPTH];
   logic [63:0] rd_pair;

   // Contents carry no reset: pointer alone marks what is valid
   for (genvar g = 0; g < DEPTH; g++)
   begin : g_entry
      always_ff @(posedge ref_clk)
      begin
         if (hw_we && hw_idx == IDX_W'(g))
         begin
            src_mem[g] <= hw_src;
            tgt_mem[g] <= hw_tgt;
         end
         else if (sw_we && sw_idx == IDX_W'(g))
         begin
            for (int b = 0; b < 4; b++)
            begin
               if (sw_be[b] && sw_tgt)
                  tgt_mem[g][(sw_hi ? 32 : 0) + b*8 +: 8] <= sw_data[b*8 +: 8];
               else if (sw_be[b])
                  src_mem[g][(sw_hi ? 32 : 0) + b*8 +: 8] <= sw_data[b*8 +: 8];
            end
         end
      end
   end

   always_comb
   begin
      rd_pair = rd_tgt ? tgt_mem[rd_idx] : src_mem[rd_idx];
      rd_word = rd_hi ? rd_pair[63:32] : rd_pair[31:0];
   end
endmodule
`default_nettype wire
